//--- bench/bcb_exec_props.sv
// port assertions for the execution unit
`timescale 1ns/1ps
module bcb_exec_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic [bcb_pkg::PC_W-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire bcb_pkg::bcb_dm_req_t dm_req,
  input wire logic [7:0] dm_rdata,
  input wire logic neg_flag,
  input wire logic [3:0] bank_select_reg,
  input wire bcb_pkg::bcb_phase_t phase,
  input wire logic idle_cycle
);
  import bcb_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // copy of the decoded word, taken where the unit samples it
  logic [15:0] ir_q;
  logic [15:0] ir_d;
  logic [7:0] f;
  logic [PC_W-1:0] disp;
  always_comb begin
    ir_d = ir_q;
    if (phase == BCB_Q1 && !idle_cycle) begin
      ir_d = prog_data;
    end
  end
  always_ff @(posedge mclk) begin
    ir_q <= rst ? IR_IDLE : ir_d;
  end
  assign f = ir_q[7:0];
  assign disp = {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
  // ==========================================================================
  sequence s_clr;
    phase == BCB_Q1 && !idle_cycle && prog_data[15:12] == OPC_BIT_CLEAR;
  endsequence
  sequence s_br(logic v);
    phase == BCB_Q4 && !idle_cycle && ir_q[15:8] == OPC_BRANCH_NEG && $past(neg_flag) == v;
  endsequence
  chk_read_in_q2: assert property (s_clr |=> dm_req.re && phase == BCB_Q2)
    else $error("no read in Q2");
  chk_write_in_q4: assert property (dm_req.re |=> !dm_req.re ##1 dm_req.we && phase == BCB_Q4)
    else $error("no write in Q4");
  chk_bit_cleared: assert property (dm_req.we |-> dm_req.wdata == ($past(dm_rdata) & ~(8'h01 << ir_q[11:9])))
    else $error("bad cleared byte");
  chk_banked_addr: assert property (dm_req.re && ir_q[ACC_BIT] |-> dm_req.addr == {$past(bank_select_reg), f})
    else $error("bad banked address");
  chk_access_addr: assert property (dm_req.re && !ir_q[ACC_BIT] && f >= ACC_SPLIT |-> dm_req.addr == {ACC_HI_BANK, f})
    else $error("bad access address");
  chk_taken_pc: assert property (s_br(1'b1) |=> prog_addr == $past(prog_addr) + PC_STEP + $past(disp))
    else $error("bad branch target");
  chk_taken_idle: assert property (s_br(1'b1) |=> idle_cycle [*4] ##1 !idle_cycle)
    else $error("bad idle cycle");
  chk_untaken_step: assert property (s_br(1'b0) |=> prog_addr == $past(prog_addr) + PC_STEP && !idle_cycle)
    else $error("bad untaken step");
endmodule
bind bcb_exec bcb_exec_props chk (.mclk(mclk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
  .dm_req(dm_req), .dm_rdata(dm_rdata), .neg_flag(neg_flag), .bank_select_reg(bank_select_reg),
  .phase(phase), .idle_cycle(idle_cycle));

//--- bench/bcb_mem.sv
// program and data memory model facing the execution unit
`timescale 1ns/1ps
module bcb_mem (
  // clock
  input wire logic mclk,
  // program side
  input wire logic [bcb_pkg::PC_W-1:0] prog_addr,
  output logic [15:0] prog_data,
  // data side
  input wire bcb_pkg::bcb_dm_req_t dm_req,
  output logic [7:0] dm_rdata
);
  import bcb_pkg::*;
  logic [7:0] ram [0:4095];
  logic [15:0] rom [0:15];
  initial begin
    rom = '{1: 16'h9205, 2: 16'h9f22, 3: 16'h9070, 4: 16'he605, 5: 16'he603, 6: 16'h9470,
      12: 16'h9605, default: 16'h0000};
    foreach (ram[i]) ram[i] = 8'hff;
    dm_rdata = 8'h00;
  end
  // words past the table read as nops so the pc runs on harmlessly
  assign prog_data = (prog_addr < 21'h000020) ? rom[prog_addr[4:1]] : 16'h0000;
  // read data stands only in the cycle after re; otherwise it toggles
  always @(posedge mclk) begin
    dm_rdata <= dm_req.re ? ram[dm_req.addr] : ~dm_rdata;
    if (dm_req.we) begin
      ram[dm_req.addr] <= dm_req.wdata;
    end
  end
endmodule

//--- bench/testbench.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
module testbench;
  import bcb_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic neg_flag = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [PC_W-1:0] prog_addr;
  logic [15:0] prog_data;
  bcb_dm_req_t dm_req;
  logic [7:0] dm_rdata;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  bcb_phase_t phase;
  logic idle_cycle;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  bcb_exec DUT (.mclk(mclk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .neg_flag(neg_flag), .bank_select_reg(4'h5), .index_base(12'h300), .phase(phase),
    .idle_cycle(idle_cycle), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));
  bcb_mem mem (.mclk(mclk), .prog_addr(prog_addr), .prog_data(prog_data), .dm_req(dm_req), .dm_rdata(dm_rdata));
  // negative only while the second branch word is in flight
  always @(posedge mclk) begin
    neg_flag <= (prog_addr == 21'h00000a);
    cyc <= cyc + 1;
    if (cyc == 300) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // word 0 is a nop so the extended set is on before the first indexed clear
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // bits other than the extended-set enable must read back as zero
    reg_wr(REG_CTRL, 8'hff);
    reg_rd(REG_CTRL, d);
    check("ctrl", d, 8'h01);
    // status of the taken branch stands through the whole idle cycle
    wait (idle_cycle);
    reg_rd(REG_STAT, d);
    check("stat", d, 8'h06);
    wait (prog_addr == 21'h000014);
    @(posedge mclk);
    check("indexed", mem.ram[12'h305], 8'hfd);
    check("banked", mem.ram[12'h522], 8'h7f);
    check("access", mem.ram[12'hf70], 8'hfe);
    check("skipped", mem.ram[12'hf70] & 8'h04, 8'h04);
    check("low bank", mem.ram[12'h005], 8'hff);
    reg_rd(REG_PC_LO, d);
    check("pc low", d, 8'h14);
    reg_rd(REG_PC_HI, d);
    check("pc high", d, 8'h00);
    // extended set off from here, so the clear at 18h lands in bank 0
    reg_wr(REG_CTRL, 8'h00);
    wait (prog_addr == 21'h00001a);
    @(posedge mclk);
    check("bank 0", mem.ram[12'h005], 8'hf7);
    report_and_stop();
  end
endmodule

//--- include/bcb_pkg.sv
// constants, types and encodings for the bit-clear / branch-if-negative execution unit
package bcb_pkg;

  // ==========================================================================
  // widths
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam int RA_W = 2;

  // ==========================================================================
  // instruction encodings and field positions
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [7:0] OPC_BRANCH_NEG = 8'he6;
  localparam int OPC4_LSB = 12;
  localparam int OPC8_LSB = 8;
  localparam int BIT_LSB = 9;
  localparam int ACC_BIT = 8;
  localparam logic [15:0] IR_IDLE = 16'h0000;

  // ==========================================================================
  // addressing
  localparam logic [7:0] IDX_MAX = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;

  // ==========================================================================
  // program counter
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // ==========================================================================
  // software register port
  localparam logic [RA_W-1:0] REG_CTRL = 2'h0;
  localparam logic [RA_W-1:0] REG_STAT = 2'h1;
  localparam logic [RA_W-1:0] REG_PC_LO = 2'h2;
  localparam logic [RA_W-1:0] REG_PC_HI = 2'h3;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    BCB_Q1 = 2'b00,
    BCB_Q2 = 2'b01,
    BCB_Q3 = 2'b11,
    BCB_Q4 = 2'b10
  } bcb_phase_t;

  typedef struct packed {
    logic [DA_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } bcb_dm_req_t;

  localparam bcb_dm_req_t DM_IDLE = '{addr: 12'h000, wdata: 8'h00, we: 1'b0, re: 1'b0};

endpackage

//--- src/bcb_addr.sv
// data memory address resolution for bit-oriented file operands
`timescale 1ns/1ps
module bcb_addr (
  // operand fields
  input wire logic [7:0] file_addr,
  input wire logic access_flag,
  // addressing context
  input wire logic ext_en,
  input wire logic [3:0] bank_select_reg,
  input wire logic [bcb_pkg::DA_W-1:0] index_base,
  // resolved address
  output logic [bcb_pkg::DA_W-1:0] data_addr
);
  import bcb_pkg::*;

  always_comb begin
    if (!access_flag && ext_en && file_addr <= IDX_MAX) begin
      // indexed literal offset from the index base
      data_addr = DA_W'(index_base + {4'h0, file_addr});
    end else if (!access_flag) begin
      // low part of access bank in bank 0, upper part maps onto the special registers
      if (file_addr < ACC_SPLIT) begin
        data_addr = {ACC_LO_BANK, file_addr};
      end else begin
        data_addr = {ACC_HI_BANK, file_addr};
      end
    end else begin
      data_addr = {bank_select_reg, file_addr};
    end
  end

endmodule

//--- src/bcb_exec.sv
// four-phase execution unit for bit clear in file and branch if negative
`timescale 1ns/1ps
module bcb_exec (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // program memory
  output logic [bcb_pkg::PC_W-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  // data memory
  output bcb_pkg::bcb_dm_req_t dm_req,
  input wire logic [7:0] dm_rdata,
  // core context
  input wire logic neg_flag,
  input wire logic [3:0] bank_select_reg,
  input wire logic [bcb_pkg::DA_W-1:0] index_base,
  // phase indication
  output bcb_pkg::bcb_phase_t phase,
  output logic idle_cycle,
  // software register port
  input wire logic [bcb_pkg::RA_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata
);
  import bcb_pkg::*;

  // ==========================================================================
  // state
  bcb_phase_t phase_q, phase_d;
  logic [15:0] ir_q, ir_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [PC_W-1:0] target_q, target_d;
  logic [7:0] offset_q, offset_d;
  logic take_q, take_d;
  logic flush_q, flush_d;
  bcb_dm_req_t dm_q, dm_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] stat_q, stat_d;

  // ==========================================================================
  // decode
  logic fetch_is_clear;
  logic ir_is_clear;
  logic ir_is_branch;
  logic [DA_W-1:0] fetch_addr;
  logic [7:0] clear_mask;
  logic [PC_W-1:0] displacement;

  // decoding at Q1 looks at the fetched word directly so the read can go out in Q2
  assign fetch_is_clear = !flush_q && prog_data[15:OPC4_LSB] == OPC_BIT_CLEAR;
  assign ir_is_clear = ir_q[15:OPC4_LSB] == OPC_BIT_CLEAR;
  assign ir_is_branch = ir_q[15:OPC8_LSB] == OPC_BRANCH_NEG;
  assign clear_mask = ~(8'h01 << ir_q[BIT_LSB +: 3]);
  // sign extend and double the offset
  assign displacement = {{(PC_W-9){offset_q[7]}}, offset_q, 1'b0};

  bcb_addr u_addr (
    .file_addr(prog_data[7:0]),
    .access_flag(prog_data[ACC_BIT]),
    .ext_en(ctrl_q[CTRL_EXT_BIT]),
    .bank_select_reg(bank_select_reg),
    .index_base(index_base),
    .data_addr(fetch_addr)
  );

  // ==========================================================================
  // quarter phase sequencing and execution
  always_comb begin
    phase_d = phase_q;
    ir_d = ir_q;
    pc_d = pc_q;
    target_d = target_q;
    offset_d = offset_q;
    take_d = take_q;
    flush_d = flush_q;
    dm_d = dm_q;
    dm_d.re = 1'b0;
    dm_d.we = 1'b0;
    stat_d = stat_q;
    case (phase_q)
      BCB_Q1: begin
        phase_d = BCB_Q2;
        // an idle cycle after a taken branch executes nothing
        if (flush_q) begin
          ir_d = IR_IDLE;
        end else begin
          ir_d = prog_data;
        end
        if (fetch_is_clear) begin
          dm_d.addr = fetch_addr;
          dm_d.re = 1'b1;
        end
      end
      BCB_Q2: begin
        phase_d = BCB_Q3;
        if (ir_is_branch) begin
          offset_d = ir_q[7:0];
        end
      end
      BCB_Q3: begin
        phase_d = BCB_Q4;
        if (ir_is_clear) begin
          // read data from Q2 arrives now and is written back in Q4
          dm_d.wdata = dm_rdata & clear_mask;
          dm_d.we = 1'b1;
        end
        if (ir_is_branch) begin
          // pc still holds the branch address, hence the extra step
          target_d = PC_W'(pc_q + PC_STEP + displacement);
          take_d = neg_flag;
        end else begin
          take_d = 1'b0;
        end
      end
      BCB_Q4: begin
        phase_d = BCB_Q1;
        stat_d = {flush_q, take_q, ir_is_branch, ir_is_clear};
        if (flush_q) begin
          // target already loaded; pc stays on it
          flush_d = 1'b0;
        end else if (ir_is_branch && take_q) begin
          pc_d = target_q;
          flush_d = 1'b1;
        end else begin
          // untaken branch does nothing else in Q4
          pc_d = PC_W'(pc_q + PC_STEP);
        end
        take_d = 1'b0;
      end
      default: begin
        phase_d = BCB_Q1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_q <= BCB_Q1;
      ir_q <= IR_IDLE;
      pc_q <= PC_RESET;
      target_q <= PC_RESET;
      offset_q <= 8'h00;
      take_q <= 1'b0;
      flush_q <= 1'b0;
      dm_q <= DM_IDLE;
      stat_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      ir_q <= ir_d;
      pc_q <= pc_d;
      target_q <= target_d;
      offset_q <= offset_d;
      take_q <= take_d;
      flush_q <= flush_d;
      dm_q <= dm_d;
      stat_q <= stat_d;
    end
  end

  // ==========================================================================
  // software register port
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = 8'h00;
    if (reg_we && reg_addr == REG_CTRL) begin
      // only the extended-set enable is implemented
      ctrl_d = reg_wdata & (8'h01 << CTRL_EXT_BIT);
    end
    if (reg_re) begin
      case (reg_addr)
        REG_CTRL: rdata_d = ctrl_q;
        REG_STAT: rdata_d = {4'h0, stat_q};
        REG_PC_LO: rdata_d = pc_q[7:0];
        REG_PC_HI: rdata_d = pc_q[15:8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  assign prog_addr = pc_q;
  assign dm_req = dm_q;
  assign phase = phase_q;
  assign idle_cycle = flush_q;
  assign reg_rdata = rdata_q;

endmodule

//--- src/bcb_unused_guard.sv
// spare source slot: the execution unit needs no logic beyond bcb_exec and bcb_addr
